//--- src/refpos_regs.svh
// register offsets, codes, reset values and timing for reference positioning
`ifndef REFPOS_REGS_SVH
`define REFPOS_REGS_SVH
`define OFS_MODE 8'h00
`define OFS_CONFIG 8'h04
`define OFS_SOURCE 8'h08
`define OFS_TARGET 8'h0c
`define OFS_SIGCORR 8'h10
`define OFS_LOADCORR 8'h14
`define OFS_ACTIVITY 8'h18
`define OFS_WAIT 8'h1c
`define OFS_POLES 8'h20
`define OFS_DECEL 8'h24
`define OFS_STATUS 8'h28
`define OFS_ROTATIONS 8'h2c
`define MODE_OFF 2'h0
`define MODE_REF 2'h1
`define MODE_AXLE 2'h2
`define CFG_110 16'h006e
`define CFG_210 16'h00d2
`define CFG_410 16'h019a
`define SRC_RISE_BASE 8'h0a
`define SRC_BOTH_BASE 8'h14
`define ACT_END 3'h0
`define ACT_EDGE_SAME 3'h1
`define ACT_EDGE_REV 3'h2
`define ACT_OFF 3'h3
`define ACT_TIME_SAME 3'h4
`define ACT_TIME_REV 3'h5
`define WAIT_MAX_MS 22'h36ee80
`define RST_POLES 4'h2
`define RST_DECEL 16'h0005
`define RST_SOURCE 8'h02
`define CLK_MHZ 200
`define TICK_US 10
`define TICK_CYCLES (`CLK_MHZ * `TICK_US)
`define TICKS_PER_MS 100
`define UNITS_PER_MREV 100000
`define LOAD_SCALE 1000
`define BRAKE_SCALE 100
`define SYNC_FILL 2'h3
`endif

//--- src/refpos_pkg.sv
// types shared by the reference positioning block
package refpos_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_DELAY, ST_HOLD, ST_BRAKE, ST_STOPPING,
    ST_POST, ST_WAIT_EDGE, ST_WAIT_TIME, ST_OFF, ST_DONE
  } state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic hold_freq;
    logic [23:0] hold_value;
    logic brake;
    logic stop_general;
    logic stage_off;
    logic start;
    logic start_cw;
  } drive_cmd_t;
endpackage : refpos_pkg

//--- src/reference_positioning_control.sv
// reference positioning: edge-triggered revolution count and distance stop
`include "refpos_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module reference_positioning_control (
  input wire logic clock,
  input wire logic reset,
  input wire refpos_pkg::reg_req_t bus,
  output logic [31:0] rdata,
  input wire logic [6:1] digital_input_x,
  input wire logic [23:0] freq_actual,
  input wire logic ramp_active,
  input wire logic turning_cw,
  output refpos_pkg::drive_cmd_t drive
);
  import refpos_pkg::*;

  // scaled target in 1e-8 electrical revolutions
  function automatic logic [55:0] scale_target(input logic [29:0] t, input logic [3:0] p);
    scale_target = 56'(t) * 56'(p) * 56'(`UNITS_PER_MREV);
  endfunction : scale_target

  // brake when remaining <= f^2 / (2a), all in 1e-8 erev
  function automatic logic brake_need(input logic [23:0] f, input logic [15:0] a,
                                      input logic signed [57:0] rem);
    logic [79:0] lhs;
    logic [79:0] rhs;
    lhs = 80'(rem) * 80'(a) * 80'd2;
    rhs = 80'(f) * 80'(f) * 80'(`BRAKE_SCALE);
    brake_need = (rem <= 58'sd0) || (lhs <= rhs);
  endfunction : brake_need

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [1:0] mode_q;
  logic [15:0] config_q;
  logic [7:0] source_q;
  logic [29:0] target_q;
  logic signed [15:0] sigcorr_q;
  logic signed [15:0] loadcorr_q;
  logic [2:0] activity_q;
  logic [21:0] wait_q;
  logic [3:0] poles_q;
  logic [15:0] decel_q;
  logic [31:0] mrev_q;
  logic short_q;
  state_t state_q;
  state_t state_d;

  // software writes; waiting time clamped to its maximum
  always_ff @(posedge clock) begin
    if (reset) begin
      mode_q <= `MODE_OFF;
      config_q <= `CFG_110;
      source_q <= `RST_SOURCE;
      target_q <= '0;
      sigcorr_q <= '0;
      loadcorr_q <= '0;
      activity_q <= `ACT_END;
      wait_q <= '0;
      poles_q <= `RST_POLES;
      decel_q <= `RST_DECEL;
    end else if (bus.wr) begin
      case (bus.addr)
        `OFS_MODE: mode_q <= bus.wdata[1:0];
        `OFS_CONFIG: config_q <= bus.wdata[15:0];
        `OFS_SOURCE: source_q <= bus.wdata[7:0];
        `OFS_TARGET: target_q <= bus.wdata[29:0];
        `OFS_SIGCORR: sigcorr_q <= bus.wdata[15:0];
        `OFS_LOADCORR: loadcorr_q <= bus.wdata[15:0];
        `OFS_ACTIVITY: activity_q <= bus.wdata[2:0];
        `OFS_WAIT: wait_q <= (bus.wdata > 32'(`WAIT_MAX_MS)) ? `WAIT_MAX_MS
                             : bus.wdata[21:0];
        `OFS_POLES: poles_q <= (bus.wdata[3:0] == 4'h0) ? 4'h1 : bus.wdata[3:0];
        `OFS_DECEL: decel_q <= (bus.wdata[15:0] == 16'h0) ? 16'h1 : bus.wdata[15:0];
        default: ;
      endcase
    end
  end

  // mode gating against the active configuration
  logic cfg_ok;
  logic ref_en;
  logic axle_sel;
  assign cfg_ok = (config_q == `CFG_110) || (config_q == `CFG_410)
                  || (config_q == `CFG_210);
  assign ref_en = (mode_q == `MODE_REF) && cfg_ok;
  assign axle_sel = (mode_q == `MODE_AXLE) && (config_q == `CFG_210);

  // read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata <= '0;
    end else if (bus.rd) begin
      case (bus.addr)
        `OFS_MODE: rdata <= 32'(mode_q);
        `OFS_CONFIG: rdata <= 32'(config_q);
        `OFS_SOURCE: rdata <= 32'(source_q);
        `OFS_TARGET: rdata <= 32'(target_q);
        `OFS_SIGCORR: rdata <= 32'(sigcorr_q);
        `OFS_LOADCORR: rdata <= 32'(loadcorr_q);
        `OFS_ACTIVITY: rdata <= 32'(activity_q);
        `OFS_WAIT: rdata <= 32'(wait_q);
        `OFS_POLES: rdata <= 32'(poles_q);
        `OFS_DECEL: rdata <= 32'(decel_q);
        `OFS_STATUS: rdata <= {25'h0, short_q, axle_sel, ref_en, state_q};
        `OFS_ROTATIONS: rdata <= mrev_q;
        default: rdata <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers; a level counts once stages two and three agree
  logic [6:1] sync1_q;
  logic [6:1] sync2_q;
  logic [6:1] sync3_q;
  logic [6:1] stable_q;
  logic [6:1] stable_prev_q;
  logic [1:0] fill_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      stable_q <= '0;
      stable_prev_q <= '0;
      fill_q <= '0;
    end else begin
      sync1_q <= digital_input_x;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (fill_q != `SYNC_FILL) begin
        // pipeline still filling: adopt the pin level so a high idle pin gives no edge
        fill_q <= fill_q + 2'h1;
        stable_q <= sync2_q;
        stable_prev_q <= sync2_q;
      end else begin
        stable_q <= (sync2_q & sync3_q) | (stable_q & (sync2_q | sync3_q));
        stable_prev_q <= stable_q;
      end
    end
  end

  // edge selection by source code
  logic ref_edge;
  always_comb begin
    ref_edge = 1'b0;
    for (int x = 1; x <= 6; x++) begin
      if ((x == 2 || x == 3 || x == 6) && source_q == 8'(x)
          && stable_prev_q[x] && !stable_q[x])
        ref_edge = 1'b1;
      if (source_q == 8'(`SRC_RISE_BASE + x) && !stable_prev_q[x] && stable_q[x])
        ref_edge = 1'b1;
      if (source_q == 8'(`SRC_BOTH_BASE + x) && (stable_prev_q[x] != stable_q[x]))
        ref_edge = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // 10 us tick and 1 ms tick, both one-cycle enables
  logic [10:0] tick_cnt_q;
  logic [6:0] ms_cnt_q;
  logic tick;
  logic ms_tick;
  assign tick = (tick_cnt_q == 11'(`TICK_CYCLES - 1));
  assign ms_tick = tick && (ms_cnt_q == 7'(`TICKS_PER_MS - 1));
  always_ff @(posedge clock) begin
    if (reset) begin
      tick_cnt_q <= '0;
      ms_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick ? 11'h0 : tick_cnt_q + 11'h1;
      if (tick)
        ms_cnt_q <= (ms_cnt_q == 7'(`TICKS_PER_MS - 1)) ? 7'h0 : ms_cnt_q + 7'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reference capture and correction terms
  logic take_ref;
  logic [39:0] preload;
  logic [55:0] tgt_e_q;
  logic signed [57:0] load_e;
  logic signed [57:0] rem_now;
  logic [47:0] travel_q;
  logic [23:0] f0_q;
  logic brake_now;
  assign preload = sigcorr_q[15] ? 40'h0 : 40'(freq_actual) * 40'(sigcorr_q);
  assign load_e = 58'(loadcorr_q) * 58'sd`LOAD_SCALE;
  assign rem_now = $signed({2'b00, tgt_e_q}) + load_e - $signed({10'h0, travel_q});
  assign brake_now = brake_need(f0_q, decel_q, rem_now);

  // distance travelled since reference, integrated per tick
  logic [39:0] frac_q;
  logic [39:0] unit_mrev;
  logic counting;
  assign unit_mrev = 40'(poles_q) * 40'(`UNITS_PER_MREV);
  assign counting = (state_q != ST_IDLE) && (state_q != ST_DELAY);
  always_ff @(posedge clock) begin
    if (reset) begin
      travel_q <= '0;
      frac_q <= '0;
      mrev_q <= '0;
    end else if (take_ref) begin
      travel_q <= 48'(preload);
      frac_q <= preload;
      mrev_q <= '0;
    end else if (counting) begin
      if (tick) begin
        travel_q <= travel_q + 48'(freq_actual);
        frac_q <= frac_q + 40'(freq_actual);
      end else if (frac_q >= unit_mrev) begin
        // one mechanical milli-revolution per cycle, ample for 2000 cycles
        frac_q <= frac_q - unit_mrev;
        mrev_q <= mrev_q + 32'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state sequencing
  logic [15:0] delay_q;
  logic [21:0] wait_cnt_q;
  always_comb begin
    state_d = state_q;
    take_ref = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (ref_edge) begin
          if (sigcorr_q[15]) begin
            state_d = ST_DELAY;
          end else begin
            take_ref = 1'b1;
            state_d = (target_q == 30'h0) ? ST_STOPPING : ST_HOLD;
          end
        end
      end
      ST_DELAY: begin
        if (tick && delay_q <= 16'h1) begin
          take_ref = 1'b1;
          state_d = (target_q == 30'h0) ? ST_STOPPING : ST_HOLD;
        end
      end
      ST_HOLD: if (brake_now) state_d = ST_BRAKE;
      ST_BRAKE: if (freq_actual == 24'h0) state_d = ST_POST;
      ST_STOPPING: if (freq_actual == 24'h0) state_d = ST_POST;
      ST_POST: begin
        case (activity_q)
          `ACT_EDGE_SAME, `ACT_EDGE_REV: state_d = ST_WAIT_EDGE;
          `ACT_OFF: state_d = ST_OFF;
          `ACT_TIME_SAME, `ACT_TIME_REV: state_d = ST_WAIT_TIME;
          default: state_d = ST_DONE;
        endcase
      end
      ST_WAIT_EDGE: if (ref_edge) state_d = ST_IDLE;
      ST_WAIT_TIME: if (wait_cnt_q == 22'h0) state_d = ST_IDLE;
      ST_OFF: state_d = ST_OFF;
      ST_DONE: if (freq_actual != 24'h0) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
    // a disabled block neither moves nor captures a reference
    if (!ref_en) begin
      state_d = ST_IDLE;
      take_ref = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) state_q <= ST_IDLE;
    else state_q <= state_d;
  end

  // negative correction delay and waiting-time counters
  always_ff @(posedge clock) begin
    if (reset) begin
      delay_q <= '0;
      wait_cnt_q <= '0;
    end else begin
      if (state_q == ST_IDLE)
        delay_q <= 16'(-sigcorr_q);
      else if (state_q == ST_DELAY && tick)
        delay_q <= delay_q - 16'h1;
      if (state_q == ST_POST)
        wait_cnt_q <= wait_q;
      else if (state_q == ST_WAIT_TIME && ms_tick && wait_cnt_q != 22'h0)
        wait_cnt_q <= wait_cnt_q - 22'h1;
    end
  end

  // frozen frequency, direction and short-distance flag
  logic dir_q;
  always_ff @(posedge clock) begin
    if (reset) begin
      f0_q <= '0;
      dir_q <= 1'b1;
      short_q <= 1'b0;
      tgt_e_q <= '0;
    end else if (take_ref) begin
      f0_q <= freq_actual;
      dir_q <= turning_cw;
      tgt_e_q <= scale_target(target_q, poles_q);
      // too short: braking starts at once and overshoots the target
      short_q <= brake_need(freq_actual, decel_q,
                            $signed({2'b00, scale_target(target_q, poles_q)})
                            + load_e);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // drive commands, registered from the next state
  logic restart;
  logic reverse;
  assign restart = (state_q == ST_WAIT_EDGE || state_q == ST_WAIT_TIME)
                   && state_d == ST_IDLE && ref_en;
  assign reverse = (activity_q == `ACT_EDGE_REV) || (activity_q == `ACT_TIME_REV);
  always_ff @(posedge clock) begin
    if (reset) begin
      drive <= '0;
    end else begin
      drive.hold_freq <= (state_d == ST_HOLD);
      drive.hold_value <= take_ref ? freq_actual : f0_q;
      drive.brake <= (state_d == ST_BRAKE);
      drive.stop_general <= (state_d == ST_STOPPING) || (state_d == ST_DONE)
                            || (state_d == ST_POST && activity_q == `ACT_END);
      drive.stage_off <= (state_d == ST_OFF);
      drive.start <= restart;
      if (restart)
        drive.start_cw <= reverse ? !dir_q : dir_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  mode_off_a: assert property (!ref_en |=> state_q == ST_IDLE)
    else $error("positioning active while disabled");
  cfg_gate_a: assert property (mode_q == `MODE_REF && config_q != `CFG_110
    && config_q != `CFG_410 && config_q != `CFG_210 |=> state_q == ST_IDLE && !drive.hold_freq)
    else $error("reference enabled in wrong configuration");
  axle_gate_a: assert property (axle_sel |-> config_q == `CFG_210)
    else $error("axle selected outside configuration 210");
  fall_edge_a: assert property (ref_edge && source_q == `RST_SOURCE |->
    $past(stable_q[2]) && !stable_q[2])
    else $error("falling edge source misfired");
  rise_edge_a: assert property (ref_edge && source_q == 8'h10 |->
    !$past(stable_q[6]) && stable_q[6])
    else $error("rising edge source misfired");
  any_edge_a: assert property (ref_edge && source_q == 8'h15 |->
    $changed(stable_q[1]))
    else $error("either edge source misfired");
  zero_stop_a: assert property (take_ref && target_q == 30'h0 |=>
    drive.stop_general && !drive.hold_freq)
    else $error("zero distance did not stop at once");
  freeze_hold_a: assert property (state_q == ST_HOLD && $past(state_q) == ST_HOLD
    && state_d == ST_HOLD |=> drive.hold_freq && drive.hold_value == $past(drive.hold_value))
    else $error("held frequency moved");
  stage_off_a: assert property (state_q == ST_POST && activity_q == `ACT_OFF |=>
    ##1 drive.stage_off || !ref_en)
    else $error("output stage not switched off");
  ramp_freeze_a: assert property (take_ref && ramp_active && target_q != 30'h0 |=>
    drive.hold_freq && drive.hold_value == $past(freq_actual))
    else $error("frequency not frozen during ramp");
  reverse_start_a: assert property (restart && reverse |=> drive.start
    && drive.start_cw == !dir_q)
    else $error("reversal restart in wrong direction");
  wait_load_a: assert property (state_q == ST_POST |=> wait_cnt_q == $past(wait_q))
    else $error("waiting time not loaded");
endmodule : reference_positioning_control
`default_nettype wire

//--- tb/motor_model.sv
// behavioural motor and frequency path facing the positioning block
`timescale 1ns/1ps
`default_nettype none
module motor_model #(
  parameter logic [23:0] RAMP_STEP = 24'h0003e8,
  parameter logic [23:0] DEC_STEP = 24'h061a80
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [23:0] set_freq,
  input var refpos_pkg::drive_cmd_t drive,
  output logic [23:0] freq_actual,
  output logic ramp_active,
  output logic turning_cw
);
  import refpos_pkg::*;
  logic stopped_q;
  logic stop_req;

  //////////////////////////////////////////////////////////////////////////////
  // stop commands come over the drive path, never over the digital inputs
  assign stop_req = drive.brake | drive.stop_general | drive.stage_off;
  assign ramp_active = (freq_actual != set_freq) && !stopped_q;

  // stopped until a restart pulse; restart wins on its own cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      stopped_q <= 1'b0;
    end else if (drive.start) begin
      stopped_q <= 1'b0;
    end else if (stop_req) begin
      stopped_q <= 1'b1;
    end
  end

  // direction changes only with a restart
  always_ff @(posedge clock) begin
    if (reset) begin
      turning_cw <= 1'b1;
    end else if (drive.start) begin
      turning_cw <= drive.start_cw;
    end
  end

  // decel is far steeper than real so a stop fits in a short run
  always_ff @(posedge clock) begin
    if (reset) begin
      freq_actual <= set_freq;
    end else if (stopped_q || stop_req) begin
      freq_actual <= (freq_actual > DEC_STEP) ? freq_actual - DEC_STEP : 24'h0;
    end else if (drive.hold_freq) begin
      freq_actual <= drive.hold_value;
    end else if (freq_actual + RAMP_STEP < set_freq) begin
      freq_actual <= freq_actual + RAMP_STEP;
    end else if (freq_actual > set_freq + RAMP_STEP) begin
      freq_actual <= freq_actual - RAMP_STEP;
    end else begin
      freq_actual <= set_freq;
    end
  end
endmodule : motor_model
`default_nettype wire

//--- tb/reference_positioning_control_tb_top.sv
// self-checking bench for reference positioning control
`include "refpos_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module reference_positioning_control_tb_top;
  import refpos_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  reg_req_t bus = '0;
  logic [31:0] rdata;
  logic [6:1] din = 6'h00;
  logic [23:0] set_freq = 24'hf42400;
  logic [23:0] freq_actual;
  logic ramp_active;
  logic turning_cw;
  drive_cmd_t drive;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [15:0] cfg_t[7] = '{`CFG_110, `CFG_110, `CFG_410, `CFG_210, 16'h00c8, `CFG_210, `CFG_110};
  logic [1:0] mode_t[7] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2};
  logic [1:0] en_t[7] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h0, 2'h2, 2'h0};
  logic [7:0] src_t[7] = '{8'h02, 8'h03, 8'h06, 8'h0b, 8'h10, 8'h15, 8'h18};
  int pin_t[7] = '{2, 3, 6, 1, 6, 1, 4};
  logic init_t[7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

  always #2.5 clock = ~clock;

  reference_positioning_control DUT (.clock(clock), .reset(reset), .bus(bus), .rdata(rdata),
    .digital_input_x(din), .freq_actual(freq_actual), .ramp_active(ramp_active),
    .turning_cw(turning_cw), .drive(drive));

  motor_model motor (.clock(clock), .reset(reset), .set_freq(set_freq), .drive(drive),
    .freq_actual(freq_actual), .ramp_active(ramp_active), .turning_cw(turning_cw));

  //////////////////////////////////////////////////////////////////////////////
  // hang guard, well above the expected run of about 20000 cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors = num_errors + 1;
      results();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, seen);
      num_errors++;
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    bus <= '{1'b1, 1'b0, a, v};
    @(posedge clock);
    bus <= '0;
  endtask : wr

  // read data stand from the cycle after the strobe is taken until the next read
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    bus <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge clock);
    bus <= '0;
    #1;
    d = rdata;
  endtask : rd

  // sel 0 hold, 1 restart, 2 general stop; n reaches lim when never seen
  task automatic wait_sig(input int sel, input int lim, output int n);
    logic [2:0] v;
    n = 0;
    v = 3'h0;
    while (n < lim && v[sel] !== 1'b1) begin
      @(posedge clock);
      #1;
      v = {drive.stop_general, drive.start, drive.hold_freq};
      n++;
    end
  endtask : wait_sig

  task automatic edge_set(input int pin, input logic lvl, input int sel, input int lim,
                          output int n);
    @(posedge clock);
    din[pin] <= lvl;
    wait_sig(sel, lim, n);
  endtask : edge_set

  // registers are written with the mode last so settling inputs raise no reference
  task automatic setup(input logic [7:0] src, input logic [29:0] tgt, input logic [2:0] act,
                       input logic [15:0] dec, input logic [3:0] pp, input logic [15:0] corr,
                       input logic [6:1] lv, input logic [23:0] f);
    @(posedge clock);
    reset <= 1'b1;
    din <= lv;
    set_freq <= f;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    wr(`OFS_SOURCE, {24'h0, src});
    wr(`OFS_TARGET, {2'h0, tgt});
    wr(`OFS_ACTIVITY, {29'h0, act});
    wr(`OFS_DECEL, {16'h0, dec});
    wr(`OFS_POLES, {28'h0, pp});
    wr(`OFS_SIGCORR, {16'h0, corr});
    wr(`OFS_MODE, {30'h0, `MODE_REF});
    repeat (4) @(posedge clock);
  endtask : setup

  task automatic results();
    $display("counts: %0d checked, %0d mismatches", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [31:0] r1;
    int n;
    longint diff;
    longint expd;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    rd(`OFS_CONFIG, d);
    check("config", d, 32'h0000006e);
    rd(`OFS_WAIT, d);
    check("wait", d, 32'h0);
    wr(`OFS_WAIT, 32'hffffffff);
    rd(`OFS_WAIT, d);
    check("wait clamp", d, 32'h0036ee80);
    rd(8'hfc, d);
    check("unmapped", d, 32'h0);
    $display("test registers done");
    // off mode in 110, reference and axle modes against allowed and disallowed configurations
    for (int i = 0; i < 7; i++) begin
      wr(`OFS_CONFIG, {16'h0, cfg_t[i]});
      wr(`OFS_MODE, {30'h0, mode_t[i]});
      rd(`OFS_STATUS, d);
      check("enables", {30'h0, d[5:4]}, {30'h0, en_t[i]});
    end
    $display("test modes done");
    // opposite transition first, then the selected one; either-edge sources fire on the first
    for (int i = 0; i < 7; i++) begin
      setup(src_t[i], 30'h3b9aca00, 3'h0, 16'hffff, 4'h1, 16'h0, {6{init_t[i]}}, 24'hf42400);
      edge_set(pin_t[i], !init_t[i], 0, 16, n);
      check("first edge", {31'h0, n < 16}, {31'h0, src_t[i] > 8'h14});
      if (n >= 16) begin
        edge_set(pin_t[i], init_t[i], 0, 16, n);
        check("second edge", {31'h0, n < 16}, 32'h1);
      end
    end
    $display("test sources done");
    // zero distance with every post activity, zero waiting time
    for (int a = 0; a < 6; a++) begin
      setup(8'h0b, 30'h0, a[2:0], 16'hffff, 4'h1, 16'h0, 6'h00, 24'hf42400);
      edge_set(1, 1'b1, 2, 16, n);
      check("zero target stop", {31'h0, n < 16}, 32'h1);
      wait_sig(1, 200, n);
      check("timed restart", {31'h0, n < 200}, {31'h0, a > 3});
      if (a == 1 || a == 2) begin
        @(posedge clock);
        din[1] <= 1'b0;
        repeat (10) @(posedge clock);
        edge_set(1, 1'b1, 1, 16, n);
        check("edge restart", {31'h0, n < 16}, 32'h1);
      end
      if (a != 0 && a != 3) begin
        check("restart dir", {31'h0, drive.start_cw}, {31'h0, a == 1 || a == 4});
      end
      if (a == 0 || a == 3) begin
        check("general stop", {31'h0, drive.stop_general}, {31'h0, a == 0});
        check("stage off", {31'h0, drive.stage_off}, {31'h0, a == 3});
      end
    end
    $display("test activities done");
    // reference in mid ramp, long distance: frozen, no brake, counting revolutions
    setup(8'h0b, 30'h3b9aca00, 3'h0, 16'hffff, 4'h1, 16'h0, 6'h00, 24'h0f4240);
    @(posedge clock);
    set_freq <= 24'hf42400;
    repeat (2000) @(posedge clock);
    edge_set(1, 1'b1, 0, 16, n);
    repeat (3) @(posedge clock);
    #1;
    check("frozen freq", {8'h0, freq_actual}, {8'h0, drive.hold_value});
    check("mid ramp", {31'h0, drive.hold_value > 24'h0f4240 && drive.hold_value < 24'hf42400}, 32'h1);
    check("early brake", {31'h0, drive.brake}, 32'h0);
    rd(`OFS_STATUS, d);
    check("hold status", {25'h0, d[6:0]}, 32'h00000012);
    rd(`OFS_ROTATIONS, r1);
    repeat (10000) @(posedge clock);
    rd(`OFS_ROTATIONS, d);
    diff = longint'(d) - longint'(r1);
    expd = longint'(freq_actual) * 10002 * 5 / 1000000000;
    check("rotations", {31'h0, diff + 3 >= expd && diff <= expd + 3}, 32'h1);
    $display("test freeze and count done");
    // distance below the braking minimum brakes at once
    setup(8'h0b, 30'h1, 3'h0, 16'h0005, 4'h2, 16'h0, 6'h00, 24'hf42400);
    edge_set(1, 1'b1, 0, 16, n);
    repeat (4) @(posedge clock);
    #1;
    check("short brake", {31'h0, drive.brake}, 32'h1);
    rd(`OFS_STATUS, d);
    check("short flag", {31'h0, d[6]}, 32'h1);
    $display("test short distance done");
    // a load correction of -100 pulls a target just past the braking minimum inside it
    for (int k = 0; k < 2; k++) begin
      setup(8'h0b, 30'h00989681, 3'h0, 16'h0032, 4'h1, 16'h0, 6'h00, 24'h0f4240);
      wr(`OFS_LOADCORR, (k == 1) ? 32'hffffff9c : 32'h0);
      edge_set(1, 1'b1, 0, 16, n);
      rd(`OFS_STATUS, d);
      check("load short", {31'h0, d[6]}, 32'(k));
    end
    $display("test load correction done");
    // negative signal correction of three 10 us ticks delays the reference
    setup(8'h0b, 30'h3b9aca00, 3'h0, 16'hffff, 4'h1, 16'hfffd, 6'h00, 24'hf42400);
    edge_set(1, 1'b1, 0, 8000, n);
    check("delayed ref", {31'h0, n >= 4000 && n <= 6020}, 32'h1);
    $display("test signal correction done");
    results();
  end
endmodule : reference_positioning_control_tb_top
`default_nettype wire
